/* File: dv/dncd_ctrl_model.sv */
/*
  Controller model that drives the command pins of the decoder.
  Assumes callers start a command just after a rising clock edge.
*/
`timescale 1ns/1ns
module dncd_ctrl_model
  import dncd_pkg::*;
(
  // Clock
  input  wire logic            core_clk_i,
  // Command pins
  output dncd_pkg::dncd_pins_s pins_o
);
  initial
  begin
    pins_o = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1, default: '0};
  end

  // one code per call, held until the next call
  task automatic cmd(input logic [3:0] code, input logic cke, input logic [2:0] ba,
                     input logic [15:0] addr);
    {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = code;
    pins_o.cke = cke;
    pins_o.ba = ba;
    pins_o.addr = addr;
    pins_o.odt = ~pins_o.odt;
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic desel();
    pins_o.cs_n = 1'b1;
    {pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = ~{pins_o.ras_n, pins_o.cas_n, pins_o.we_n};
    pins_o.ba = ~pins_o.ba;
    pins_o.addr = ~pins_o.addr;
  endtask
endmodule

/* File: dv/dncd_decode_bench.sv */
/*
  Self-checking bench for the command decoder.
  Assumes the controller model drives all command pins.
*/
`timescale 1ns/1ns
module dncd_decode_bench;
  import dncd_pkg::*;
  localparam logic [3:0] C_MRS = 4'h0;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_WR  = 4'h4;
  localparam logic [3:0] C_RD  = 4'h5;
  localparam logic [3:0] C_CAL = 4'h6;
  localparam logic [3:0] C_NOP = 4'h7;
  logic             core_clk_i;
  logic             rst_n_i;
  logic             clk_en_i;
  logic             otf_en_i;
  logic             fixed_bl8_i;
  dncd_pins_s       pins;
  dncd_ev_s         ev;
  logic [NBANK-1:0] bank_open;
  logic [NMR-1:0]   mr_sel;
  logic             busy;
  logic             idle;
  logic             pd_act;
  logic             pd_pre;
  logic             ill;
  int               n_errors;
  int               checked;

  dncd_ctrl_model u_m (.core_clk_i(core_clk_i), .pins_o(pins));
  dncd_decode u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .pins_i(pins), .otf_en_i(otf_en_i), .fixed_bl8_i(fixed_bl8_i), .event_o(ev),
    .bank_open_o(bank_open), .mr_sel_o(mr_sel), .burst_busy_o(busy), .idle_o(idle),
    .pd_active_o(pd_act), .pd_precharge_o(pd_pre), .illegal_o(ill));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    u_m.desel();
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic t_cal();
    u_m.cmd(C_CAL, 1'b1, 3'h0, 16'h0400);
    chk("cal_cmd", 16'(DNCD_CAL), 16'(ev.cmd));
    chk("cal_first", 16'h0003, 16'({ev.cal_long, ev.cal_init}));
    u_m.cmd(C_CAL, 1'b1, 3'h0, 16'h0400);
    chk("cal_oper", 16'h0002, 16'({ev.cal_long, ev.cal_init}));
    u_m.cmd(C_CAL, 1'b1, 3'h0, 16'h0000);
    chk("cal_short", 16'h0000, 16'(ev.cal_long));
    $display("t_cal done");
  endtask

  task automatic t_mrs();
    for (int b = 0; b < 4; b++)
    begin
      u_m.cmd(C_MRS, 1'b1, 3'(b), 16'h0000);
      chk("mr_sel", 16'(4'h1 << b), 16'(mr_sel));
    end
    u_m.cmd(C_REF, 1'b1, 3'h0, 16'h0000);
    chk("ref_flag", 16'h0001, 16'(ill));
    chk("ref_state", 16'h0008, 16'({bank_open, mr_sel}));
    u_m.cmd(C_RD, 1'b1, 3'h4, 16'h0400);
    chk("rd_closed", 16'h0001, 16'({ev.valid, ill}));
    $display("t_mrs done");
  endtask

  task automatic t_read();
    int n;
    for (int k = 0; k < 4; k++)
    begin
      otf_en_i = (k < 2);
      fixed_bl8_i = (k == 3);
      u_m.cmd(C_ACT, 1'b1, 3'h1, 16'h0000);
      chk("bank_open", 16'h0002, 16'(bank_open));
      u_m.cmd((k == 2) ? C_WR : C_RD, 1'b1, 3'h1, (k % 2 == 1) ? 16'h0400 : 16'h1400);
      chk("rd_cmd", (k == 2) ? 16'(DNCD_WR) : 16'(DNCD_RD), 16'(ev.cmd));
      chk("rd_ap", 16'h0003, 16'({ev.valid, ev.auto_pre}));
      chk("rd_bank", 16'h0001, 16'(ev.bank));
      chk("rd_bl8", 16'(k == 0 || k == 3), 16'(ev.bl8));
      chk("idle_burst", 16'h0000, 16'(idle));
      n = 0;
      while (busy === 1'b1 && n < 20)
      begin
        n++;
        if (n == 1)
          u_m.cmd(C_NOP, 1'b1, 3'h1, 16'h0000);
        else
          step(1);
      end
      chk("burst_len", (k == 0 || k == 3) ? 16'h0008 : 16'h0004, 16'(n));
      step(1);
      chk("bank_shut", 16'h0000, 16'(bank_open));
      chk("idle_after", 16'h0001, 16'(idle));
    end
    $display("t_read done");
  endtask

  task automatic t_pd();
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1)
        u_m.cmd(C_ACT, 1'b1, 3'h2, 16'h0000);
      u_m.cmd(C_NOP, 1'b0, 3'h0, 16'h0000);
      chk("pd_entry", 16'(k + 1), 16'({pd_act, pd_pre}));
      step(2);
      chk("pd_hold", 16'(k + 1), 16'({pd_act, pd_pre}));
      u_m.cmd(C_NOP, 1'b1, 3'h0, 16'h0000);
      chk("pd_exit", 16'h0000, 16'({pd_act, pd_pre, idle}));
      step(XP_CYC + 2);
      chk("idle_xp", 16'(k == 0), 16'(idle));
    end
    u_m.cmd(C_ACT, 1'b1, 3'h5, 16'h0000);
    u_m.cmd(C_PRE, 1'b1, 3'h2, 16'h0000);
    chk("pre_one", 16'h0020, 16'(bank_open));
    u_m.cmd(C_PRE, 1'b1, 3'h0, 16'h0400);
    chk("prea", 16'h0000, 16'(bank_open));
    $display("t_pd done");
  endtask

  task automatic t_freeze();
    clk_en_i = 1'b0;
    u_m.cmd(C_ACT, 1'b1, 3'h3, 16'h0000);
    chk("freeze_bank", 16'h0000, 16'(bank_open));
    chk("freeze_ev", 16'(DNCD_PREA), 16'(ev.cmd));
    clk_en_i = 1'b1;
    step(1);
    chk("thaw_bank", 16'h0000, 16'(bank_open));
    $display("t_freeze done");
  endtask

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  initial
  begin
    rst_n_i = 1'b0;
    clk_en_i = 1'b1;
    otf_en_i = 1'b1;
    fixed_bl8_i = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (6) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    step(2);
    t_cal();
    t_mrs();
    t_read();
    t_pd();
    t_freeze();
    stop_test();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    #50000;
    n_errors++;
    stop_test();
  end
endmodule

/* File: rtl/dncd_decode.sv */
/*
  Command and clock-enable decoder: classifies each sampled command,
  tracks open banks, burst activity and power-down state.
  Assumes the controller meets clock-enable hold and legal-command rules.
*/
// Operation
// - Commands are decoded only from select, strobes, clock enable and A10 (precharge all) at a rising edge.
// - Read with auto precharge is a read code with A10 high, and A12 picks chop 4 or length 8 when on-the-fly is enabled.
// - A no-operation registers nothing and does not stop work in progress.
// - With select high all inputs but clock enable are ignored and it acts as a no-operation.
// - Calibration is select low, row and column high, write low; A10 high long, low short.
// - Clock enable falling with a no-operation enters precharge or active power-down.
// - Clock enable low twice holds power-down; low then high with no-operation exits it.
// - The termination input affects neither decode nor clock-enable state.
// - Bank address picks the target bank, or one of four mode registers for a mode set.
// - Bursts always complete; fixed or on-the-fly length is chosen in mode register zero.
// - Idle only when banks closed, no burst, clock enable high and exit timing done.
// - Refresh and self-refresh encodings are unsupported and not acted on.
`timescale 1ns/1ns
module dncd_decode
  import dncd_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  clk_en_i,
  // Command pins
  input  wire dncd_pkg::dncd_pins_s  pins_i,
  // Mode register zero burst setting
  input  wire logic                  otf_en_i,
  input  wire logic                  fixed_bl8_i,
  // Status
  output dncd_pkg::dncd_ev_s         event_o,
  output logic [dncd_pkg::NBANK-1:0] bank_open_o,
  output logic [dncd_pkg::NMR-1:0]   mr_sel_o,
  output logic                       burst_busy_o,
  output logic                       idle_o,
  output logic                       pd_active_o,
  output logic                       pd_precharge_o,
  output logic                       illegal_o
);
  import dncd_pkg::*;

  function automatic dncd_cmd_e classify(input logic cs_n, input logic ras_n,
                                         input logic cas_n, input logic we_n,
                                         input logic a10);
    logic [3:0] c;
    c = {cs_n, ras_n, cas_n, we_n};
    unique casez (c)
      4'b1???: classify = DNCD_NOP;
      4'b0111: classify = DNCD_NOP;
      4'b0000: classify = DNCD_MRS;
      4'b0001: classify = DNCD_UNSUP;
      4'b0010: classify = a10 ? DNCD_PREA : DNCD_PRE;
      4'b0011: classify = DNCD_ACT;
      4'b0100: classify = DNCD_WR;
      4'b0101: classify = DNCD_RD;
      4'b0110: classify = DNCD_CAL;
      default: classify = DNCD_ILL;
    endcase
  endfunction

  dncd_pwr_e          pwr;
  dncd_pwr_e          next_pwr;
  logic               cke_prev;
  logic               cal_seen;
  logic [NBANK-1:0]   next_bank_open;
  logic [BURST_W-1:0] burst_cnt;
  logic [BURST_W-1:0] next_burst_cnt;
  logic [XP_W-1:0]    xp_cnt;
  logic [XP_W-1:0]    next_xp_cnt;
  logic               next_illegal;
  dncd_ev_s           next_event;

  wire dncd_cmd_e raw_cmd = classify(pins_i.cs_n, pins_i.ras_n, pins_i.cas_n,
                                     pins_i.we_n, pins_i.addr[A10_POS]);
  wire       cke_hh    = cke_prev && pins_i.cke;
  wire       is_nop    = (raw_cmd == DNCD_NOP);
  wire       in_pd     = (pwr != DNCD_RUN);
  wire       pd_entry  = !in_pd && cke_prev && !pins_i.cke && is_nop;
  // exit on low then high with nop
  wire       pd_exit   = in_pd && !cke_prev && pins_i.cke && is_nop;
  wire       cke_bad   = (cke_prev != pins_i.cke) && !pd_entry && !pd_exit;
  wire       pd_bad    = in_pd && !cke_prev && pins_i.cke && !is_nop;
  wire       cmd_bad   = cke_hh && (raw_cmd == DNCD_UNSUP || raw_cmd == DNCD_ILL);
  wire       run_ok    = !in_pd && cke_hh && !cmd_bad;
  wire       col_cmd   = run_ok && (raw_cmd == DNCD_RD || raw_cmd == DNCD_WR);
  wire       col_ok    = col_cmd && bank_open_o[pins_i.ba] && !burst_busy_o;
  // length from A12 only when on-the-fly enabled
  wire       sel_bl8   = otf_en_i ? pins_i.addr[A12_POS] : fixed_bl8_i;
  wire       any_open  = |bank_open_o;
  wire       bank_idle = (bank_open_o == BANKS_CLOSED) && !burst_busy_o;
  wire       burst_end = burst_busy_o && (burst_cnt == '0);

  always_comb
  begin
    next_bank_open = bank_open_o;
    if (run_ok && raw_cmd == DNCD_ACT)
      next_bank_open[pins_i.ba] = 1'b1;
    if (run_ok && raw_cmd == DNCD_PRE && !burst_busy_o)
      next_bank_open[pins_i.ba] = 1'b0;
    if (run_ok && raw_cmd == DNCD_PREA && !burst_busy_o)
      next_bank_open = BANKS_CLOSED;
    // auto precharge closes bank at burst end if no other command was registered during the burst
    if (burst_end && event_o.auto_pre)
      next_bank_open[event_o.bank] = 1'b0;
  end

  always_comb
  begin
    next_burst_cnt = burst_cnt;
    if (col_ok)
      next_burst_cnt = sel_bl8 ? BURST_BL8 : BURST_BC4;
    else if (burst_busy_o && burst_cnt != '0)
      next_burst_cnt = burst_cnt - 1'b1;
  end

  always_comb
  begin
    next_pwr = pwr;
    if (pd_entry)
      next_pwr = bank_idle ? DNCD_PD_PRE : DNCD_PD_ACT;
    else if (pd_exit)
      next_pwr = DNCD_RUN;
  end

  always_comb
  begin
    next_xp_cnt = xp_cnt;
    if (pd_exit)
      next_xp_cnt = XP_W'(XP_CYC);
    else if (xp_cnt != '0)
      next_xp_cnt = xp_cnt - 1'b1;
  end

  // deselect and nop register no event
  always_comb
  begin
    next_event          = '0;
    next_event.cmd      = raw_cmd;
    next_event.bank     = pins_i.ba;
    next_event.auto_pre = pins_i.addr[A10_POS];
    next_event.bl8      = sel_bl8;
    next_event.cal_long = pins_i.addr[A10_POS];
    next_event.cal_init = pins_i.addr[A10_POS] && !cal_seen;
    next_event.valid    = run_ok && !is_nop &&
                          (!(raw_cmd == DNCD_RD || raw_cmd == DNCD_WR) || col_ok);
    if (!next_event.valid && burst_busy_o)
    begin
      next_event       = event_o;
      next_event.valid = 1'b0;
    end
  end

  assign next_illegal = cke_bad || pd_bad || cmd_bad || (col_cmd && !col_ok);

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pwr          <= DNCD_RUN;
      cke_prev     <= 1'b0;
      cal_seen     <= 1'b0;
      bank_open_o  <= BANKS_CLOSED;
      burst_cnt    <= '0;
      burst_busy_o <= 1'b0;
      xp_cnt       <= '0;
      event_o      <= '0;
      illegal_o    <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pwr          <= next_pwr;
      cke_prev     <= pins_i.cke;
      cal_seen     <= cal_seen
                      || (next_event.valid && raw_cmd == DNCD_CAL && pins_i.addr[A10_POS]);
      bank_open_o  <= next_bank_open;
      burst_cnt    <= next_burst_cnt;
      burst_busy_o <= col_ok || (burst_busy_o && burst_cnt != '0);
      xp_cnt       <= next_xp_cnt;
      event_o      <= next_event;
      illegal_o    <= next_illegal;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mr_sel_o       <= '0;
      idle_o         <= 1'b0;
      pd_active_o    <= 1'b0;
      pd_precharge_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (run_ok && raw_cmd == DNCD_MRS)
        mr_sel_o <= NMR'(1) << pins_i.ba[1:0];
      idle_o         <= (next_bank_open == BANKS_CLOSED) && (next_burst_cnt == '0)
                        && !col_ok && !burst_busy_o && pins_i.cke
                        && next_pwr == DNCD_RUN && next_xp_cnt == '0;
      pd_active_o    <= next_pwr == DNCD_PD_ACT;
      pd_precharge_o <= next_pwr == DNCD_PD_PRE;
    end
  end

  // entry picks mode by bank state
  a_pd_entry_mode: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && pd_entry |=> (pd_precharge_o == $past(bank_idle))
    && (pd_active_o == $past(any_open || burst_busy_o)))
    else $error("power-down mode wrong");

  a_pd_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && in_pd && !cke_prev && !pins_i.cke |=> (pd_active_o || pd_precharge_o))
    else $error("power-down not held");

  a_pd_exit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && pd_exit |=> !pd_active_o && !pd_precharge_o)
    else $error("power-down not left");

  a_nop_no_event: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && pins_i.cs_n |=> !event_o.valid)
    else $error("deselect registered a command");

  a_bad_keeps: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && cmd_bad && !burst_busy_o |=> $stable(bank_open_o) && illegal_o)
    else $error("illegal command changed state");

  a_burst_len: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && col_ok && sel_bl8 ##1 clk_en_i[*7] |=> burst_busy_o)
    else $error("burst cut short");

  a_idle_cond: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    idle_o |-> bank_open_o == BANKS_CLOSED && !burst_busy_o && !in_pd && xp_cnt == '0)
    else $error("idle with activity");

  a_cal_decode: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && run_ok && raw_cmd == DNCD_CAL |=> event_o.valid && event_o.cmd == DNCD_CAL
    && event_o.cal_long == $past(pins_i.addr[A10_POS]))
    else $error("calibration decode wrong");

  a_rdap_close: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && col_ok && raw_cmd == DNCD_RD && pins_i.addr[A10_POS] && !sel_bl8
    ##1 clk_en_i[*4] |=> !bank_open_o[$past(pins_i.ba, 5)])
    else $error("auto precharge missed");

  a_cke_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && !cke_hh |=> !event_o.valid)
    else $error("command taken without clock enable");

  a_nop_burst: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && is_nop && burst_busy_o && burst_cnt != '0 |=> burst_busy_o && !event_o.valid)
    else $error("no-operation stopped a burst");

  a_rd_fields: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && col_ok |=> event_o.valid && event_o.auto_pre == $past(pins_i.addr[A10_POS])
    && event_o.bank == $past(pins_i.ba))
    else $error("column command fields wrong");

  a_act_opens: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && run_ok && raw_cmd == DNCD_ACT |=> bank_open_o[$past(pins_i.ba)])
    else $error("activate missed its bank");

  a_mrs_pick: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && run_ok && raw_cmd == DNCD_MRS |=> $onehot(mr_sel_o)
    && mr_sel_o[$past(pins_i.ba[1:0])])
    else $error("mode register select wrong");

  a_xp_settle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && pd_exit |=> !idle_o && xp_cnt != '0)
    else $error("idle during exit delay");

  // Clock enable low freezes state
  a_en_freeze: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !clk_en_i |=> $stable(bank_open_o) && $stable(event_o) && $stable(pwr))
    else $error("state moved with clock enable low");

  c_read: cover property (@(posedge core_clk_i) clk_en_i && col_ok && raw_cmd == DNCD_RD);
  c_write: cover property (@(posedge core_clk_i) clk_en_i && col_ok && raw_cmd == DNCD_WR);
  c_pd_act: cover property (@(posedge core_clk_i) pd_active_o);
  c_pd_pre: cover property (@(posedge core_clk_i) pd_precharge_o);
  c_cal: cover property (@(posedge core_clk_i) event_o.valid && event_o.cal_init);
endmodule

/* File: rtl/dncd_pkg.sv */
/*
  Shared types and constants for the memory command decoder.
  Assumes command pins are already sampled on the rising clock edge.
*/
package dncd_pkg;

  localparam int BA_W   = 3;
  localparam int ADDR_W = 16;
  localparam int NBANK  = 8;
  localparam int A10_POS = 10;
  localparam int A12_POS = 12;
  localparam int NMR     = 4;
  localparam int BURST_W = 3;
  localparam logic [BURST_W-1:0] BURST_BL8 = 3'h7;
  localparam logic [BURST_W-1:0] BURST_BC4 = 3'h3;
  localparam logic [NBANK-1:0] BANKS_CLOSED = 8'h00;
  // Settle time after power-down exit before idle counts
  localparam int T_XP_NS   = 24;
  localparam int CLK_NS    = 10;
  localparam int XP_CYC    = (T_XP_NS + CLK_NS - 1) / CLK_NS;
  localparam int XP_W      = 3;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic              odt;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } dncd_pins_s;

  typedef enum logic [3:0] {
    DNCD_NOP, DNCD_MRS, DNCD_UNSUP, DNCD_PRE, DNCD_PREA, DNCD_ACT,
    DNCD_WR, DNCD_RD, DNCD_CAL, DNCD_ILL
  } dncd_cmd_e;

  typedef enum logic [1:0] {
    DNCD_RUN, DNCD_PD_PRE, DNCD_PD_ACT
  } dncd_pwr_e;

  typedef struct packed {
    logic           valid;
    dncd_cmd_e      cmd;
    logic [BA_W-1:0] bank;
    logic           auto_pre;
    logic           bl8;
    logic           cal_long;
    logic           cal_init;
  } dncd_ev_s;

endpackage
